// *** core/fiv_pkg.sv ***
// package: register map and types for the fast interrupt vector controller
package fiv_pkg;
  localparam logic [31:0] normal_status_off    = 32'hffff0000;
  localparam logic [31:0] normal_raw_off       = 32'hffff0004;
  localparam logic [31:0] normal_enable_off    = 32'hffff0008;
  localparam logic [31:0] normal_clear_off     = 32'hffff000c;
  localparam logic [31:0] vector_base_off      = 32'hffff0014;
  localparam logic [31:0] swi_trigger_off      = 32'hffff0018;
  localparam logic [31:0] active_vector_off    = 32'hffff001c;
  localparam logic [31:0] priority_first_off   = 32'hffff0020;
  localparam logic [31:0] nesting_control_off  = 32'hffff0030;
  localparam logic [31:0] fast_status_off      = 32'hffff0100;
  localparam logic [31:0] fast_raw_off         = 32'hffff0104;
  localparam logic [31:0] fast_enable_off      = 32'hffff0108;
  localparam logic [31:0] fast_clear_off       = 32'hffff010c;
  localparam int          num_priority_regs    = 4;
  localparam int          swi_src_bit          = 1;
  localparam int          swi_fast_bit         = 2;
  localparam int          swi_normal_bit       = 1;
  localparam int          nest_normal_bit      = 0;
  localparam int          nest_fast_bit        = 1;
  localparam int          num_sources          = 28;
  localparam logic [31:0] reg_reset            = 32'h00000000;
  localparam logic [31:0] swi_mask             = 32'h00000006;
  localparam logic [31:0] nest_mask            = 32'h00000003;
  localparam logic [31:0] prio_mask            = 32'h77777777;
  typedef struct packed {
    logic        fast_line;
    logic        normal_line;
  } core_irq_t;
endpackage : fiv_pkg

// *** core/fast_interrupt_vector_ctrl.sv ***
// fast and normal interrupt masking with vectored priority encoder
// Operation
// - fast line is OR of fast status 31:1, mirrored in bit 0
// - writing one to fast enable clears that normal enable bit
// - writing one to normal enable clears that fast enable bit
// - raw source bits follow peripheral requests; read only
// - fast enable writes only set bits, zeros have no effect
// - fast clear register clears enable bits written as one
// - fast status is raw source AND fast enable
// - no vector encoding unless vectoring enabled
// - trigger bit 2 sets or clears fast raw and status bit 1
// - trigger bit 1 sets or clears normal raw and status bit 1
// - software interrupts bypass enable masks
// - nesting bit 0 vectors normal, bit 1 vectors fast
// - eight levels per type, fast and normal lines raised independently
// - each source has programmable priority 0 to 7
// - vector base holds 16 bits, upper bits read zero
// - vector reads base at 22:7 and source at 6:2
// - normal line is OR of normal status 31:1; bit 0 shows the fast line
// - normal status is normal raw AND normal enable
// - source bits follow shared map, vector numbers likewise
`timescale 1ns/1ps
`default_nettype none
module fast_interrupt_vector_ctrl
  import fiv_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_in,
  input  wire logic [31:0]          paddr_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire logic [31:0]          fast_source_in,
  input  wire logic [31:0]          normal_source_in,
  output fiv_pkg::core_irq_t        core_irq_out,
  output logic      [4:0]           fast_vector_src_out
);
  import fiv_pkg::*;

  logic [31:0] fast_sync1_reg, fast_sync2_reg;
  logic [31:0] norm_sync1_reg, norm_sync2_reg;
  logic [31:0] fast_en_reg, norm_en_reg;
  logic [31:0] swi_reg, nest_reg;
  logic [15:0] base_reg;
  logic [31:0] prio_reg [num_priority_regs];
  logic [31:0] fast_raw, norm_raw, fast_sta, norm_sta;
  logic        fast_any, norm_any;
  logic [31:1] fast_masked;

  // request pins come from other peripheral clocks: two stages first
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fast_sync1_reg <= reg_reset;
      fast_sync2_reg <= reg_reset;
      norm_sync1_reg <= reg_reset;
      norm_sync2_reg <= reg_reset;
    end else begin
      fast_sync1_reg <= fast_source_in;
      fast_sync2_reg <= fast_sync1_reg;
      norm_sync1_reg <= normal_source_in;
      norm_sync2_reg <= norm_sync1_reg;
    end
  end

  // raw sources with software bit injected unmasked
  assign fast_any = |fast_masked;
  assign fast_raw = {fast_sync2_reg[31:2],
                     fast_sync2_reg[1] | swi_reg[swi_fast_bit],
                     fast_any};
  assign norm_raw = {norm_sync2_reg[31:2],
                     norm_sync2_reg[1] | swi_reg[swi_normal_bit],
                     fast_any};
  // software bit 1 shows in status regardless of mask
  assign fast_masked = {fast_sync2_reg[31:2] & fast_en_reg[31:2],
                        (fast_sync2_reg[1] & fast_en_reg[1])
                          | swi_reg[swi_fast_bit]};
  // bit 0 mirrors the OR; built from the upper bits, so no loop
  assign fast_sta = {fast_masked, fast_any};
  assign norm_sta = {norm_raw[31:2] & norm_en_reg[31:2],
                     (norm_sync2_reg[1] & norm_en_reg[1])
                       | swi_reg[swi_normal_bit],
                     fast_any};
  assign norm_any = |norm_sta[31:1];

  // bus decode
  logic        wr_en, rd_en;
  logic        hit_fen, hit_fclr, hit_nen, hit_nclr;
  logic        hit_swi, hit_base, hit_nest, hit_prio, hit_ro, mapped;
  logic [1:0]  prio_idx;
  logic [31:0] wdata_nest;
  assign wr_en    = psel_in & penable_in & pwrite_in;
  assign rd_en    = psel_in & penable_in & ~pwrite_in;
  assign hit_fen  = paddr_in == fast_enable_off;
  assign hit_fclr = paddr_in == fast_clear_off;
  assign hit_nen  = paddr_in == normal_enable_off;
  assign hit_nclr = paddr_in == normal_clear_off;
  assign hit_swi  = paddr_in == swi_trigger_off;
  assign hit_base = paddr_in == vector_base_off;
  assign hit_nest = paddr_in == nesting_control_off;
  assign hit_prio = paddr_in[31:4] == priority_first_off[31:4]
                    && paddr_in[1:0] == 2'h0;
  assign prio_idx = paddr_in[3:2];
  assign hit_ro   = paddr_in == fast_status_off
                    || paddr_in == fast_raw_off
                    || paddr_in == normal_status_off
                    || paddr_in == normal_raw_off
                    || paddr_in == active_vector_off;
  assign mapped   = hit_fen | hit_fclr | hit_nen | hit_nclr | hit_swi
                    | hit_base | hit_nest | hit_prio | hit_ro;
  assign wdata_nest = pwdata_in & nest_mask;

  // enable masks: set-only writes, clear companions, mutual exclusion
  logic [31:0] fast_en_next, norm_en_next;
  assign fast_en_next = (wr_en & hit_fen)  ? (fast_en_reg | pwdata_in)
                      : (wr_en & hit_fclr) ? (fast_en_reg & ~pwdata_in)
                      : (wr_en & hit_nen)  ? (fast_en_reg & ~pwdata_in)
                      : fast_en_reg;
  assign norm_en_next = (wr_en & hit_nen)  ? (norm_en_reg | pwdata_in)
                      : (wr_en & hit_nclr) ? (norm_en_reg & ~pwdata_in)
                      : (wr_en & hit_fen)  ? (norm_en_reg & ~pwdata_in)
                      : norm_en_reg;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fast_en_reg <= reg_reset;
      norm_en_reg <= reg_reset;
      swi_reg     <= reg_reset;
      nest_reg    <= reg_reset;
      base_reg    <= reg_reset[15:0];
    end else begin
      fast_en_reg <= fast_en_next;
      norm_en_reg <= norm_en_next;
      if (wr_en & hit_swi) begin
        swi_reg <= pwdata_in & swi_mask;
      end
      if (wr_en & hit_nest) begin
        nest_reg <= wdata_nest;
      end
      if (wr_en & hit_base) begin
        base_reg <= pwdata_in[15:0];
      end
    end
  end

  for (genvar g = 0; g < num_priority_regs; g++) begin : g_prio
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        prio_reg[g] <= reg_reset;
      end else if (wr_en && hit_prio && prio_idx == 2'(g)) begin
        prio_reg[g] <= pwdata_in & prio_mask;
      end
    end
  end

  // source n priority lives at register n/8 nibble (n%8), low 3 bits
  function automatic logic [2:0] src_prio(input int n);
    logic [31:0] r;
    r = prio_reg[n / 8];
    return r[(n % 8) * 4 +: 3];
  endfunction

  // highest level wins, lowest number on ties (strict >)
  function automatic logic [4:0] pick(input logic [31:0] act);
    logic [2:0] best;
    logic [4:0] idx;
    logic       found;
    best  = 3'h0;
    idx   = 5'h00;
    found = 1'b0;
    for (int n = 1; n < num_sources; n++) begin
      if (act[n] && (!found || src_prio(n) > best)) begin
        best  = src_prio(n);
        idx   = 5'(n);
        found = 1'b1;
      end
    end
    return idx;
  endfunction

  logic [4:0] norm_pick, fast_pick;
  assign norm_pick = nest_reg[nest_normal_bit] ? pick(norm_sta) : 5'h00;
  assign fast_pick = nest_reg[nest_fast_bit]   ? pick(fast_sta) : 5'h00;

  logic [4:0]  norm_vec_reg;
  logic [31:0] vec_word;
  assign vec_word = {9'h000, base_reg, norm_vec_reg, 2'h0};

  logic [31:0] rd_mux;
  assign rd_mux = (paddr_in == fast_status_off)   ? fast_sta
                : (paddr_in == fast_raw_off)      ? fast_raw
                : hit_fen                         ? fast_en_reg
                : (paddr_in == normal_status_off) ? norm_sta
                : (paddr_in == normal_raw_off)    ? norm_raw
                : hit_nen                         ? norm_en_reg
                : hit_swi                         ? swi_reg
                : hit_base                        ? {16'h0000, base_reg}
                : hit_nest                        ? nest_reg
                : (paddr_in == active_vector_off) ? vec_word
                : hit_prio                        ? prio_reg[prio_idx]
                : reg_reset;

  // zero wait states; unmapped addresses answer with an error
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      prdata_out          <= reg_reset;
      pready_out          <= 1'b0;
      pslverr_out         <= 1'b0;
      core_irq_out        <= '0;
      norm_vec_reg        <= 5'h00;
      fast_vector_src_out <= 5'h00;
    end else begin
      pready_out   <= psel_in & ~penable_in;
      pslverr_out  <= psel_in & ~penable_in & ~mapped;
      prdata_out   <= (psel_in & ~pwrite_in) ? rd_mux : reg_reset;
      core_irq_out.fast_line   <= fast_any;
      core_irq_out.normal_line <= norm_any;
      norm_vec_reg        <= norm_pick;
      fast_vector_src_out <= fast_pick;
    end
  end

  // -- assertions
  property p_fast_line;
    @(posedge sys_clk_in) disable iff (rst_in)
      fast_any |=> core_irq_out.fast_line;
  endproperty
  a_fast_line: assert property (p_fast_line)
    else $error("fast line not raised");
  property p_mutex;
    @(posedge sys_clk_in) disable iff (rst_in)
      (fast_en_reg & norm_en_reg) == 32'h00000000;
  endproperty
  a_mutex: assert property (p_mutex)
    else $error("source enabled in both masks");
  property p_norm_clears_fast;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_en && hit_nen) |=> (fast_en_reg & $past(pwdata_in)) == 0;
  endproperty
  a_norm_clears_fast: assert property (p_norm_clears_fast)
    else $error("normal enable did not clear fast bit");
  property p_set_only;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_en && hit_fen) |=> (fast_en_reg & $past(fast_en_reg))
                             == $past(fast_en_reg);
  endproperty
  a_set_only: assert property (p_set_only)
    else $error("fast enable write cleared a bit");
  property p_clear;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_en && hit_fclr) |=>
        fast_en_reg == ($past(fast_en_reg) & ~$past(pwdata_in));
  endproperty
  a_clear: assert property (p_clear)
    else $error("fast clear wrong");
  property p_status;
    @(posedge sys_clk_in) disable iff (rst_in)
      fast_sta[31:2] == (fast_raw[31:2] & fast_en_reg[31:2]);
  endproperty
  a_status: assert property (p_status)
    else $error("fast status not raw and enable");
  property p_swi;
    @(posedge sys_clk_in) disable iff (rst_in)
      swi_reg[swi_fast_bit] |-> fast_sta[1] && fast_raw[1];
  endproperty
  a_swi: assert property (p_swi)
    else $error("software fast interrupt missing");
  sequence s_normal_vec_off;
    !nest_reg[nest_normal_bit] ##1 !nest_reg[nest_normal_bit];
  endsequence
  property p_novec;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_normal_vec_off |-> norm_vec_reg == 5'h00;
  endproperty
  a_novec: assert property (p_novec)
    else $error("vector produced while vectoring off");
  sequence s_fast_vec_off;
    !nest_reg[nest_fast_bit] ##1 !nest_reg[nest_fast_bit];
  endsequence
  property p_fast_novec;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_fast_vec_off |-> fast_vector_src_out == 5'h00;
  endproperty
  a_fast_novec: assert property (p_fast_novec)
    else $error("fast vector produced while vectoring off");
  property p_fast_line_low;
    @(posedge sys_clk_in) disable iff (rst_in)
      !fast_any |=> !core_irq_out.fast_line;
  endproperty
  a_fast_line_low: assert property (p_fast_line_low)
    else $error("fast line not dropped");
  property p_normal_line;
    @(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |=> core_irq_out.normal_line == $past(norm_any);
  endproperty
  a_normal_line: assert property (p_normal_line)
    else $error("normal line wrong");
  property p_fast_clears_norm;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_en && hit_fen) |=> (norm_en_reg & $past(pwdata_in)) == 0;
  endproperty
  a_fast_clears_norm: assert property (p_fast_clears_norm)
    else $error("fast enable did not clear normal bit");
  property p_swi_normal;
    @(posedge sys_clk_in) disable iff (rst_in)
      swi_reg[swi_normal_bit] |-> norm_sta[1] && norm_raw[1];
  endproperty
  a_swi_normal: assert property (p_swi_normal)
    else $error("software normal interrupt missing");
  property p_swi_write;
    @(posedge sys_clk_in) disable iff (rst_in)
      (wr_en && hit_swi) |=> swi_reg[31:3] == 29'h0 && !swi_reg[0];
  endproperty
  a_swi_write: assert property (p_swi_write)
    else $error("reserved trigger bits stored");
  property p_vec_range;
    @(posedge sys_clk_in) disable iff (rst_in)
      norm_vec_reg < 5'(num_sources)
        && fast_vector_src_out < 5'(num_sources);
  endproperty
  a_vec_range: assert property (p_vec_range)
    else $error("vector source number out of range");
  property p_fast_vec_on;
    @(posedge sys_clk_in) disable iff (rst_in)
      (nest_reg[nest_fast_bit] && |fast_sta[27:1])
        |=> fast_vector_src_out != 5'h00;
  endproperty
  a_fast_vec_on: assert property (p_fast_vec_on)
    else $error("fast vector missing while vectoring on");
  property p_norm_vec_on;
    @(posedge sys_clk_in) disable iff (rst_in)
      (nest_reg[nest_normal_bit] && |norm_sta[27:1])
        |=> norm_vec_reg != 5'h00;
  endproperty
  a_norm_vec_on: assert property (p_norm_vec_on)
    else $error("normal vector missing while vectoring on");

  // read data is registered at the setup edge, checked one later
  sequence s_read_setup(logic [31:0] addr);
    psel_in && !penable_in && !pwrite_in
      && paddr_in == addr;
  endsequence
  property p_base_read;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_read_setup(vector_base_off) |=> prdata_out[31:16] == 16'h0000;
  endproperty
  a_base_read: assert property (p_base_read)
    else $error("vector base upper bits not zero");
  property p_vec_read;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_read_setup(active_vector_off) |=>
        prdata_out[31:23] == 9'h000 && prdata_out[1:0] == 2'h0;
  endproperty
  a_vec_read: assert property (p_vec_read)
    else $error("vector reserved bits not zero");
  property p_fast_sta_read;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_read_setup(fast_status_off) |=>
        prdata_out[31:2] == $past(fast_raw[31:2] & fast_en_reg[31:2])
        && prdata_out[0] == $past(fast_any);
  endproperty
  a_fast_sta_read: assert property (p_fast_sta_read)
    else $error("fast status read wrong");
  property p_norm_sta_read;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_read_setup(normal_status_off) |=>
        prdata_out[31:2] == $past(norm_raw[31:2] & norm_en_reg[31:2])
        && prdata_out[0] == $past(fast_any);
  endproperty
  a_norm_sta_read: assert property (p_norm_sta_read)
    else $error("normal status read wrong");
endmodule : fast_interrupt_vector_ctrl
`default_nettype wire

// *** test/irq_source_model.sv ***
// peripheral interrupt request model feeding the controller
`timescale 1ns/1ps
`default_nettype none
module irq_source_model #(
  parameter int MIN_HOLD = 4
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] fast_req_in,
  input  wire logic [31:0] normal_req_in,
  output logic      [31:0] fast_source_out,
  output logic      [31:0] normal_source_out
);
  logic [3:0] hold_reg;
  wire        new_req = |(fast_req_in & ~fast_source_out) |
                        |(normal_req_in & ~normal_source_out);
  wire        holding = hold_reg != 4'h0;
  // fresh request held up at least the detection latency
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      hold_reg          <= 4'h0;
      fast_source_out   <= 32'h0;
      normal_source_out <= 32'h0;
    end else begin
      hold_reg <= new_req ? 4'(MIN_HOLD) : hold_reg - {3'h0, holding};
      fast_source_out   <= fast_req_in | (holding ? fast_source_out : 32'h0);
      normal_source_out <= normal_req_in |
                           (holding ? normal_source_out : 32'h0);
    end
  end
endmodule // irq_source_model
`default_nettype wire

// *** test/fast_interrupt_vector_ctrl_test.sv ***
// self-checking bench for the fast interrupt vector controller
`timescale 1ns/1ps
`default_nettype none
module fast_interrupt_vector_ctrl_test;
  import fiv_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] paddr = 32'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] fast_req = 32'h0;
  logic [31:0] normal_req = 32'h0;
  logic [31:0] fast_src;
  logic [31:0] normal_src;
  core_irq_t   irq;
  logic [4:0]  fvec;
  int          err_count = 0;
  int          compares = 0;
  always #12.5 clk = ~clk;
  fast_interrupt_vector_ctrl DUT (.sys_clk_in(clk), .rst_in(rst),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .fast_source_in(fast_src),
    .normal_source_in(normal_src), .core_irq_out(irq),
    .fast_vector_src_out(fvec));
  irq_source_model peripherals (.sys_clk_in(clk), .rst_in(rst),
    .fast_req_in(fast_req), .normal_req_in(normal_req),
    .fast_source_out(fast_src), .normal_source_out(normal_src));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; idle cycle after, so no double drive in one step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // waits for the answer; only the watchdog bounds this
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask
  task automatic t_reset();
    check({30'h0, irq}, 32'h0);
    rd(fast_status_off, 32'h0);
    rd(fast_raw_off, 32'h0);
    rd(fast_enable_off, 32'h0);
    rd(vector_base_off, 32'h0);
    rd(nesting_control_off, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_masks();
    wr(normal_enable_off, 32'h30);
    wr(fast_enable_off, 32'h10);
    rd(normal_enable_off, 32'h20);
    wr(fast_enable_off, 32'h0);
    rd(fast_enable_off, 32'h10);
    wr(fast_enable_off, 32'h60);
    rd(normal_enable_off, 32'h0);
    wr(normal_enable_off, 32'h40);
    rd(fast_enable_off, 32'h30);
    wr(fast_clear_off, 32'h10);
    rd(fast_enable_off, 32'h20);
    $display("test masks done");
  endtask
  task automatic t_sources();
    fast_req   <= 32'h28;
    normal_req <= 32'h40;
    repeat (6) @(posedge clk);
    rd(fast_raw_off, 32'h29);
    rd(fast_status_off, 32'h21);
    rd(normal_status_off, 32'h41);
    check({30'h0, irq}, 32'h3);
    wr(fast_raw_off, 32'h0);
    rd(fast_raw_off, 32'h29);
    fast_req   <= 32'h0;
    normal_req <= 32'h0;
    repeat (12) @(posedge clk);
    rd(fast_raw_off, 32'h0);
    check({30'h0, irq}, 32'h0);
    wr(normal_clear_off, 32'h40);
    rd(normal_enable_off, 32'h0);
    $display("test sources done");
  endtask
  task automatic t_swi();
    wr(swi_trigger_off, 32'h4);
    repeat (3) @(posedge clk);
    rd(fast_status_off, 32'h3);
    rd(fast_raw_off, 32'h3);
    check({30'h0, irq}, 32'h2);
    wr(swi_trigger_off, 32'hffff_fffa);
    repeat (3) @(posedge clk);
    rd(normal_status_off, 32'h2);
    rd(swi_trigger_off, 32'h2);
    check({30'h0, irq}, 32'h1);
    wr(swi_trigger_off, 32'h0);
    $display("test swi done");
  endtask
  task automatic t_vector();
    logic [31:0] r;
    logic        e;
    wr(vector_base_off, 32'hffff_ffff);
    rd(vector_base_off, 32'h0000_ffff);
    wr(normal_enable_off, 32'h28);
    wr(priority_first_off, 32'h0020_2000);
    rd(priority_first_off, 32'h0020_2000);
    wr(nesting_control_off, 32'h1);
    normal_req <= 32'h28;
    repeat (8) @(posedge clk);
    rd(active_vector_off, 32'h007f_ff8c);
    wr(priority_first_off, 32'h0030_2000);
    rd(active_vector_off, 32'h007f_ff94);
    wr(fast_enable_off, 32'h80);
    fast_req <= 32'h80;
    repeat (8) @(posedge clk);
    check({27'h0, fvec}, 32'h0);
    wr(nesting_control_off, 32'h3);
    repeat (3) @(posedge clk);
    check({27'h0, fvec}, 32'h7);
    apb(1'b0, 32'hffff_0040, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    $display("test vector done");
  endtask
  task automatic t_rereset();
    fast_req   <= 32'h0;
    normal_req <= 32'h0;
    rst        <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({30'h0, irq}, 32'h0);
    check({27'h0, fvec}, 32'h0);
    rd(fast_enable_off, 32'h0);
    rd(vector_base_off, 32'h0);
    $display("test rereset done");
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // generous ceiling over the roughly 200 cycles of traffic
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_masks();
    t_sources();
    t_swi();
    t_vector();
    t_rereset();
    close_out();
  end
endmodule // fast_interrupt_vector_ctrl_test
`default_nettype wire
